// *** core/ssq_params.svh ***
`ifndef SSQ_PARAMS_SVH
`define SSQ_PARAMS_SVH
// ==========================================
// Register offsets
`define SSQ_REG_CTRL 8'h00
`define SSQ_REG_START 8'h04
`define SSQ_REG_STEP 8'h08
`define SSQ_REG_NPTS 8'h0C
`define SSQ_REG_NAVG 8'h10
`define SSQ_REG_SETTLE 8'h14
`define SSQ_REG_IDELAY 8'h18
`define SSQ_REG_EDELAY 8'h1C
`define SSQ_REG_ITIME 8'h20
`define SSQ_REG_WAIT 8'h24
`define SSQ_REG_GAIN 8'h28
`define SSQ_REG_STATUS 8'h2C
`define SSQ_REG_CYCLE 8'h30
`define SSQ_REG_FREQ 8'h34
`define SSQ_REG_HSTEP 8'h38
`define SSQ_REG_LOGMUL 8'h3C
// CTRL fields
`define SSQ_CTRL_RUN 0
`define SSQ_CTRL_CYCLIC 1
`define SSQ_CTRL_LOG 2
`define SSQ_CTRL_PULSED 3
`define SSQ_CTRL_USESEQ 4
`define SSQ_CTRL_RST 32'h0000_0010
// Times in ns, clock period in ns
`define SSQ_CLK_NS 20
`define SSQ_SETTLE_NS 80
`define SSQ_IDELAY_NS 224
`define SSQ_EDELAY_NS 0
`define SSQ_ITIME_NS 1000000
`define SSQ_WAIT_NS 0
// Least times round up, none below one cycle
`define SSQ_CYC(ns) ((((ns) + `SSQ_CLK_NS - 1) / `SSQ_CLK_NS) < 1 ? 1 : (((ns) + `SSQ_CLK_NS - 1) / `SSQ_CLK_NS))
`define SSQ_NPTS_RST 32'h0000_03E9
`define SSQ_NAVG_RST 32'h0000_0001
`define SSQ_GAIN_RST 32'h0000_FFFF
`define SSQ_LOGMUL_RST 32'h0001_0000
`define SSQ_RESP_OK 2'h0
`define SSQ_RESP_ERR 2'h2
`endif

// *** core/ssq_pkg.sv ***
package ssq_pkg;
    typedef enum logic [5:0] {
        SSQ_IDLE = 6'h01,
        SSQ_SETTLE = 6'h02,
        SSQ_IDLY = 6'h04,
        SSQ_INTEG = 6'h08,
        SSQ_WAIT = 6'h10,
        SSQ_HOLD = 6'h20
    } ssq_state_e;
endpackage

// *** core/ssq_sweep_sequencer.sv ***
// Function
// - Wait settling time before measure trigger
// - Integration starts after integration delay
// - Pulsed envelope starts after envelope delay
// - Integrate for programmable integration time
// - Wait programmable interval after integration
// - Cycle time is sum, readable
// - Sequential or cyclic averaging order
// - Sweep start offset over point count
// - Linear or logarithmic point spacing
// - Gain factor scales oscillator amplitude
// - Sequencer steps frequency without host
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`include "ssq_params.svh"
module ssq_sweep_sequencer #(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Oscillator and measurement unit
    output logic [31:0] osc_freq,
    output logic [15:0] osc_gain,
    output logic osc_load,
    output logic issue_measure_trigger,
    output logic env_start,
    output logic integrate,
    output logic sweep_busy
);
    // ==========================================
    // Registers
    logic [31:0] ctrl, start_f, step_f, npts, navg, t_settle, t_idly, t_edly, t_int, t_wait, gain, logmul;
    logic [31:0] next_ctrl, next_start_f, next_step_f, next_npts, next_navg, next_t_settle;
    logic [31:0] next_t_idly, next_t_edly, next_t_int, next_t_wait, next_gain, next_logmul;
    logic aw_hold, w_hold, next_aw_hold, next_w_hold;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic host_step, wr_fire;
    logic [31:0] wmask;
    // Sequencer state
    ssq_pkg::ssq_state_e state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt, edcnt, next_edcnt;
    logic env_pend, next_env_pend;
    logic [31:0] pt, next_pt, av, next_av, freq, next_freq;
    logic [63:0] prod;
    logic next_load, next_trig, next_env, next_integ;
    logic [31:0] cycle_sum;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{w_strb[i]}};
        end
    end
    assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
    assign cycle_sum = t_settle + t_idly + t_int + t_wait;
    assign prod = 64'(freq) * 64'(logmul);
    // ==========================================
    // Bus next state
    always_comb begin
        next_aw_hold = aw_hold;
        next_w_hold = w_hold;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_ctrl = ctrl;
        next_start_f = start_f;
        next_step_f = step_f;
        next_npts = npts;
        next_navg = navg;
        next_t_settle = t_settle;
        next_t_idly = t_idly;
        next_t_edly = t_edly;
        next_t_int = t_int;
        next_t_wait = t_wait;
        next_gain = gain;
        next_logmul = logmul;
        host_step = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_hold = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_hold = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `SSQ_RESP_OK;
            unique case (aw_addr)
                `SSQ_REG_CTRL: next_ctrl = (ctrl & ~wmask) | (w_data & wmask);
                `SSQ_REG_START: next_start_f = (start_f & ~wmask) | (w_data & wmask);
                `SSQ_REG_STEP: next_step_f = (step_f & ~wmask) | (w_data & wmask);
                `SSQ_REG_NPTS: next_npts = (npts & ~wmask) | (w_data & wmask);
                `SSQ_REG_NAVG: next_navg = (navg & ~wmask) | (w_data & wmask);
                `SSQ_REG_SETTLE: next_t_settle = (t_settle & ~wmask) | (w_data & wmask);
                `SSQ_REG_IDELAY: next_t_idly = (t_idly & ~wmask) | (w_data & wmask);
                `SSQ_REG_EDELAY: next_t_edly = (t_edly & ~wmask) | (w_data & wmask);
                `SSQ_REG_ITIME: next_t_int = (t_int & ~wmask) | (w_data & wmask);
                `SSQ_REG_WAIT: next_t_wait = (t_wait & ~wmask) | (w_data & wmask);
                `SSQ_REG_GAIN: next_gain = (gain & ~wmask) | (w_data & wmask);
                `SSQ_REG_LOGMUL: next_logmul = (logmul & ~wmask) | (w_data & wmask);
                `SSQ_REG_HSTEP: host_step = 1'b1;
                default: next_bresp = `SSQ_RESP_ERR;
            endcase
        end
        if (state == ssq_pkg::SSQ_IDLE && ctrl[`SSQ_CTRL_RUN] && !(wr_fire && aw_addr == `SSQ_REG_CTRL)) begin
            next_ctrl[`SSQ_CTRL_RUN] = 1'b0;
        end
        next_arready = !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = `SSQ_RESP_OK;
            unique case (s_axi_araddr)
                `SSQ_REG_CTRL: next_rdata = ctrl;
                `SSQ_REG_START: next_rdata = start_f;
                `SSQ_REG_STEP: next_rdata = step_f;
                `SSQ_REG_NPTS: next_rdata = npts;
                `SSQ_REG_NAVG: next_rdata = navg;
                `SSQ_REG_SETTLE: next_rdata = t_settle;
                `SSQ_REG_IDELAY: next_rdata = t_idly;
                `SSQ_REG_EDELAY: next_rdata = t_edly;
                `SSQ_REG_ITIME: next_rdata = t_int;
                `SSQ_REG_WAIT: next_rdata = t_wait;
                `SSQ_REG_GAIN: next_rdata = gain;
                `SSQ_REG_LOGMUL: next_rdata = logmul;
                `SSQ_REG_STATUS: next_rdata = {26'h0, state};
                `SSQ_REG_CYCLE: next_rdata = cycle_sum;
                `SSQ_REG_FREQ: next_rdata = freq;
                `SSQ_REG_HSTEP: next_rdata = pt;
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = `SSQ_RESP_ERR;
                end
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SSQ_RESP_OK;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SSQ_RESP_OK;
            ctrl <= `SSQ_CTRL_RST;
            start_f <= 32'h0;
            step_f <= 32'h0;
            npts <= `SSQ_NPTS_RST;
            navg <= `SSQ_NAVG_RST;
            t_settle <= 32'(`SSQ_CYC(`SSQ_SETTLE_NS));
            t_idly <= 32'(`SSQ_CYC(`SSQ_IDELAY_NS));
            t_edly <= 32'(`SSQ_CYC(`SSQ_EDELAY_NS));
            t_int <= 32'(`SSQ_CYC(`SSQ_ITIME_NS));
            t_wait <= 32'(`SSQ_CYC(`SSQ_WAIT_NS));
            gain <= `SSQ_GAIN_RST;
            logmul <= `SSQ_LOGMUL_RST;
        end else begin
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= !next_aw_hold;
            s_axi_wready <= !next_w_hold;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            ctrl <= next_ctrl;
            start_f <= next_start_f;
            step_f <= next_step_f;
            npts <= next_npts;
            navg <= next_navg;
            t_settle <= next_t_settle;
            t_idly <= next_t_idly;
            t_edly <= next_t_edly;
            t_int <= next_t_int;
            t_wait <= next_t_wait;
            gain <= next_gain;
            logmul <= next_logmul;
        end
    end
    // ==========================================
    // Sweep sequencer
    always_comb begin
        next_state = state;
        next_cnt = cnt - 1'b1;
        next_edcnt = (edcnt != '0) ? edcnt - 1'b1 : edcnt;
        next_env_pend = env_pend;
        next_pt = pt;
        next_av = av;
        next_freq = freq;
        next_load = 1'b0;
        next_trig = 1'b0;
        next_env = 1'b0;
        next_integ = 1'b0;
        if (env_pend && edcnt == '0) begin
            next_env = 1'b1;
            next_env_pend = 1'b0;
        end
        unique case (state)
            ssq_pkg::SSQ_IDLE: begin
                if (ctrl[`SSQ_CTRL_RUN]) begin
                    next_pt = 32'h0;
                    next_av = 32'h0;
                    next_freq = start_f;
                    next_load = 1'b1;
                    next_cnt = CNT_W'(t_settle);
                    next_state = ssq_pkg::SSQ_SETTLE;
                end
            end
            ssq_pkg::SSQ_SETTLE: begin
                if (cnt <= 1) begin
                    next_trig = 1'b1;
                    next_cnt = CNT_W'(t_idly);
                    next_edcnt = CNT_W'(t_edly);
                    next_env_pend = ctrl[`SSQ_CTRL_PULSED];
                    next_state = ssq_pkg::SSQ_IDLY;
                end
            end
            ssq_pkg::SSQ_IDLY: begin
                if (cnt <= 1) begin
                    next_integ = 1'b1;
                    next_cnt = CNT_W'(t_int);
                    next_state = ssq_pkg::SSQ_INTEG;
                end
            end
            ssq_pkg::SSQ_INTEG: begin
                next_integ = cnt > 1;
                if (cnt <= 1) begin
                    next_cnt = CNT_W'(t_wait);
                    next_state = ssq_pkg::SSQ_WAIT;
                end
            end
            ssq_pkg::SSQ_WAIT: begin
                if (cnt <= 1) begin
                    next_cnt = CNT_W'(t_settle);
                    next_state = ssq_pkg::SSQ_SETTLE;
                    if (ctrl[`SSQ_CTRL_CYCLIC]) begin
                        if (pt + 1 >= npts) begin
                            next_pt = 32'h0;
                            next_av = av + 1;
                            next_freq = start_f;
                        end else begin
                            next_pt = pt + 1;
                            next_freq = ctrl[`SSQ_CTRL_LOG] ? prod[47:16] : freq + step_f;
                        end
                        if (pt + 1 >= npts && av + 1 >= navg) begin
                            next_state = ssq_pkg::SSQ_IDLE;
                        end
                    end else begin
                        if (av + 1 >= navg) begin
                            next_av = 32'h0;
                            next_pt = pt + 1;
                            next_freq = ctrl[`SSQ_CTRL_LOG] ? prod[47:16] : freq + step_f;
                        end else begin
                            next_av = av + 1;
                        end
                        if (av + 1 >= navg && pt + 1 >= npts) begin
                            next_state = ssq_pkg::SSQ_IDLE;
                        end
                    end
                    next_load = next_state != ssq_pkg::SSQ_IDLE;
                    if (!ctrl[`SSQ_CTRL_USESEQ] && next_state != ssq_pkg::SSQ_IDLE) begin
                        next_state = ssq_pkg::SSQ_HOLD;
                        next_load = 1'b0;
                    end
                end
            end
            ssq_pkg::SSQ_HOLD: begin
                if (host_step) begin
                    next_load = 1'b1;
                    next_cnt = CNT_W'(t_settle);
                    next_state = ssq_pkg::SSQ_SETTLE;
                end
            end
            default: next_state = ssq_pkg::SSQ_IDLE;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ssq_pkg::SSQ_IDLE;
            cnt <= '0;
            edcnt <= '0;
            env_pend <= 1'b0;
            pt <= 32'h0;
            av <= 32'h0;
            freq <= 32'h0;
            osc_freq <= 32'h0;
            osc_gain <= 16'h0;
            osc_load <= 1'b0;
            issue_measure_trigger <= 1'b0;
            env_start <= 1'b0;
            integrate <= 1'b0;
            sweep_busy <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            edcnt <= next_edcnt;
            env_pend <= next_env_pend;
            pt <= next_pt;
            av <= next_av;
            freq <= next_freq;
            osc_freq <= next_freq;
            osc_gain <= gain[15:0];
            osc_load <= next_load;
            issue_measure_trigger <= next_trig;
            env_start <= next_env;
            integrate <= next_integ;
            sweep_busy <= next_state != ssq_pkg::SSQ_IDLE;
        end
    end
endmodule

// *** tb/ssq_sweep_sequencer_properties.sv ***
`timescale 1ns/10ps
module ssq_checker #(
    parameter int T_INT = 3
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Sweep outputs
    input wire logic osc_load,
    input wire logic issue_measure_trigger,
    input wire logic env_start,
    input wire logic integrate,
    input wire logic sweep_busy
);
    // ==========================================
    // Helper state
    logic armed;
    logic next_armed;
    int run_len;
    int next_run_len;
    always_comb begin
        next_armed = issue_measure_trigger || (armed && !integrate);
        next_run_len = integrate ? run_len + 1 : 0;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed <= 1'b0;
            run_len <= 0;
        end else begin
            armed <= next_armed;
            run_len <= next_run_len;
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    load_pulse_a: assert property (osc_load |=> !osc_load) else $error("load not a pulse");
    settle_gap_a: assert property (osc_load |-> !issue_measure_trigger) else $error("no settling gap");
    trig_pulse_a: assert property (issue_measure_trigger |=> !issue_measure_trigger) else $error("trigger long");
    delay_armed_a: assert property ($rose(integrate) |-> armed) else $error("integration untriggered");
    integ_len_a: assert property ($fell(integrate) |-> run_len == T_INT) else $error("bad integration length");
    quiet_integ_a: assert property (integrate |-> !issue_measure_trigger && !osc_load) else $error("step in integration");
    idle_quiet_a: assert property (!sweep_busy |-> !integrate && !issue_measure_trigger) else $error("idle activity");
    env_busy_a: assert property (env_start |-> sweep_busy) else $error("envelope while idle");
    write_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid) else $error("late write response");
    read_resp_a: assert property (rd_taken |=> s_axi_rvalid) else $error("late read data");
endmodule
bind ssq_sweep_sequencer ssq_checker #(.T_INT(3)) u_checker (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .osc_load(osc_load),
    .issue_measure_trigger(issue_measure_trigger), .env_start(env_start), .integrate(integrate),
    .sweep_busy(sweep_busy));

// *** tb/ssq_host_model.sv ***
`timescale 1ns/10ps
`include "ssq_params.svh"
module ssq_host_model (
    // Clock
    input wire logic aclk,
    // Write channels
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // Read channels
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // ==========================================
    // Word write, each channel dropped once taken
    task automatic write_reg(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
        logic aw_hit, w_hit, b_hit, done;
        done = 1'b0;
        resp = 2'h3;
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            b_hit = s_axi_bvalid && s_axi_bready;
            if (b_hit) resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
            if (b_hit) begin
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // ==========================================
    // Word read
    task automatic read_reg(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
        logic ar_hit, r_hit, done;
        done = 1'b0;
        data = '0;
        resp = 2'h3;
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ar_hit = s_axi_arvalid && s_axi_arready;
            r_hit = s_axi_rvalid && s_axi_rready;
            if (r_hit) begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
            end
            @(posedge aclk);
            if (ar_hit) s_axi_arvalid <= 1'b0;
            if (r_hit) begin
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // Host-driven step to the next point
    task automatic step_point();
        logic [1:0] resp;
        write_reg(`SSQ_REG_HSTEP, 32'h0000_0001, resp);
    endtask
endmodule

// *** tb/ssq_sweep_sequencer_bench.sv ***
`timescale 1ns/10ps
`include "ssq_params.svh"
module ssq_sweep_sequencer_bench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic osc_load, issue_measure_trigger, env_start, integrate, sweep_busy;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, osc_freq, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] osc_gain;
    logic prev_int = 1'b0;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    int q_load[$], q_trig[$], q_rise[$], q_fall[$], q_env[$];
    logic [31:0] q_freq[$];
    int m_set[2], m_idl[2], m_wt[2], m_env[2], m_cyc[2];
    int t_set[2] = '{4, 10};
    int t_idl[2] = '{12, 20};
    int t_wt[2] = '{1, 6};
    int t_env[2] = '{1, 5};
    ssq_sweep_sequencer u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_freq,
        .osc_gain, .osc_load, .issue_measure_trigger, .env_start, .integrate, .sweep_busy);
    ssq_host_model u_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // ==========================================
    // Clock, event log and timeout
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(negedge aclk) begin
        cyc++;
        if (osc_load === 1'b1) q_load.push_back(cyc);
        if (issue_measure_trigger === 1'b1) begin
            q_trig.push_back(cyc);
            q_freq.push_back(osc_freq);
        end
        if (env_start === 1'b1) q_env.push_back(cyc);
        if (integrate === 1'b1 && !prev_int) q_rise.push_back(cyc);
        if (integrate !== 1'b1 && prev_int) q_fall.push_back(cyc);
        prev_int = (integrate === 1'b1);
        if (cyc > 30000) begin
            failures++;
            wrap_up();
        end
    end
    // ==========================================
    // Tasks
    task automatic wrap_up();
        if (failures == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.write_reg(a, d, rs);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        u_host.read_reg(a, rd, rs);
        check(rd, exp);
    endtask
    task automatic start(input logic [31:0] ctrl);
        q_load = {};
        q_trig = {};
        q_rise = {};
        q_fall = {};
        q_env = {};
        q_freq = {};
        wr(`SSQ_REG_CTRL, ctrl);
    endtask
    task automatic wait_idle();
        @(negedge aclk);
        while (sweep_busy === 1'b1) @(negedge aclk);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        aresetn = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`SSQ_REG_CTRL, `SSQ_CTRL_RST);
        rd_chk(`SSQ_REG_NPTS, `SSQ_NPTS_RST);
        rd_chk(`SSQ_REG_NAVG, `SSQ_NAVG_RST);
        rd_chk(`SSQ_REG_CYCLE, 32'h0000_C361);
        rd_chk(8'h40, 32'h0000_0000);
        check({30'h0, rs}, {30'h0, `SSQ_RESP_ERR});
        wr(`SSQ_REG_CYCLE, 32'h0000_0005);
        check({30'h0, rs}, {30'h0, `SSQ_RESP_ERR});
        wr(`SSQ_REG_ITIME, 32'h0000_0003);
        wr(`SSQ_REG_NPTS, 32'h0000_0002);
        for (int k = 0; k < 2; k++) begin
            wr(`SSQ_REG_SETTLE, t_set[k]);
            wr(`SSQ_REG_IDELAY, t_idl[k]);
            wr(`SSQ_REG_WAIT, t_wt[k]);
            wr(`SSQ_REG_EDELAY, t_env[k]);
            rd_chk(`SSQ_REG_CYCLE, t_set[k] + t_idl[k] + 3 + t_wt[k]);
            start(32'h0000_0019);
            wait_idle();
            check(q_trig.size(), 2);
            check(q_fall[0] - q_rise[0], 3);
            m_set[k] = q_trig[0] - q_load[0];
            m_idl[k] = q_rise[0] - q_trig[0];
            m_wt[k] = q_trig[1] - q_fall[0];
            m_env[k] = q_env[0] - q_trig[0];
            m_cyc[k] = q_trig[1] - q_trig[0];
            check(m_set[k], t_set[k]);
            check(m_idl[k], t_idl[k]);
            check(m_cyc[k], t_set[k] + t_idl[k] + 3 + t_wt[k]);
        end
        check(m_set[1] - m_set[0], 6);
        check(m_idl[1] - m_idl[0], 8);
        check(m_wt[1] - m_wt[0], 11);
        check(m_env[1] - m_env[0], 4);
        check(m_cyc[1] - m_cyc[0], 19);
        wr(`SSQ_REG_START, 32'h0000_0100);
        wr(`SSQ_REG_STEP, 32'h0000_0010);
        wr(`SSQ_REG_NPTS, 32'h0000_0003);
        wr(`SSQ_REG_NAVG, 32'h0000_0002);
        for (int k = 0; k < 2; k++) begin
            start(k ? 32'h0000_0013 : 32'h0000_0011);
            wait_idle();
            check(q_freq.size(), 6);
            check(q_env.size(), 0);
            for (int i = 0; i < 6; i++) check(q_freq[i], 32'h100 + 32'h10 * (k ? i % 3 : i / 2));
        end
        wr(`SSQ_REG_LOGMUL, 32'h0002_0000);
        wr(`SSQ_REG_NAVG, 32'h0000_0001);
        start(32'h0000_0015);
        wait_idle();
        rd_chk(`SSQ_REG_STATUS, 32'h0000_0001);
        for (int i = 0; i < 3; i++) check(q_freq[i], 32'h100 << i);
        wr(`SSQ_REG_GAIN, 32'h0000_8000);
        repeat (2) @(negedge aclk);
        check({16'h0, osc_gain}, 32'h0000_8000);
        wr(`SSQ_REG_NPTS, 32'h0000_0002);
        start(32'h0000_0001);
        repeat (200) @(negedge aclk);
        check(q_trig.size(), 1);
        u_host.step_point();
        repeat (200) @(negedge aclk);
        check(q_trig.size(), 2);
        wrap_up();
    end
endmodule
